// ===== dv/fsu_issue_model.sv
// issue logic model: hands one subtract request to the unit per call
// assumes the unit takes a request at the edge where valid is high
`timescale 1ns/100ps
module fsu_issue_model import fsu_pkg::*; (
    input  wire logic  clk_i,
    output fsu_req_type req_o
);
    initial req_o = '0;
    // operands scrambled after the take edge so stale values never look valid
    task automatic send(input logic lng, input logic [4:0] dst, input logic [63:0] s2, input logic [63:0] s1);
        @(posedge clk_i);
        req_o <= {1'b1, lng, lng ? {dst[4:1], 1'b0} : dst, s1, s2};
        @(posedge clk_i);
        req_o <= {1'b0, ~req_o[133:0]};
    endtask : send
endmodule : fsu_issue_model

// ===== dv/fsu_top_sva.sv
// checker of the float subtract unit ports
// assumes one clock domain and a synchronous active high reset
`timescale 1ns/100ps
module fsu_top_chk import fsu_pkg::*; (
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [31:0] prdata_o,
    input wire fsu_req_type req_i,
    input wire fsu_rsp_type rsp_o,
    input wire fsu_flt_type flt_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // apb access phases
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_access;
        psel_i && penable_i;
    endsequence
    chk_one_answer: assert property (req_i.valid |=> rsp_o.we ^ flt_o.valid)
        else $error("request not answered by exactly one of write or fault");
    chk_no_stray: assert property (!req_i.valid |=> !rsp_o.we && !flt_o.valid)
        else $error("answer without request");
    chk_short_hi: assert property (rsp_o.we && !rsp_o.pair |-> rsp_o.word_hi == 32'h0)
        else $error("short result carries a high word");
    chk_pair_kind: assert property (req_i.valid ##1 rsp_o.we |-> rsp_o.pair == $past(req_i.long_op))
        else $error("pair flag differs from operand size");
    chk_pair_even: assert property (rsp_o.we && rsp_o.pair |-> rsp_o.dst_reg[0] == 1'b0)
        else $error("long result to odd register");
    chk_dst_track: assert property (req_i.valid ##1 rsp_o.we |-> rsp_o.dst_reg[4:1] == $past(req_i.dst_reg[4:1]))
        else $error("result to wrong register");
    chk_fault_cause: assert property (flt_o.valid |-> flt_o.code != 5'h0)
        else $error("fault without a cause");
    chk_apb_wait: assert property (s_setup ##1 s_access |-> !pready_o ##1 pready_o)
        else $error("access not ended after one wait state");
    chk_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    chk_err_ready: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
        else $error("error outside ready or with data");
    // an op answer and the interrupt leave the same edge; a mask write raises it at the edge that ends its ready cycle
    chk_irq_cause: assert property ($rose(irq_o) |-> flt_o.valid || rsp_o.we || $past(pready_o))
        else $error("interrupt rose without event or register write");
endmodule : fsu_top_chk
bind fsu_top fsu_top_chk u_chk (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o), .req_i(req_i), .rsp_o(rsp_o),
    .flt_o(flt_o), .irq_o(irq_o));

// ===== dv/tb_float_subtract_unit.sv
// self-checking bench of the float subtract unit
// assumes one apb master here and the issue model on the request port
`timescale 1ns/100ps
`include "fsu_map.svh"
module tb_float_subtract_unit;
    import fsu_pkg::*;
    localparam logic [63:0] ONE = 64'h3FF0000000000000, INF = 64'h7FF0000000000000, NINF = 64'hFFF0000000000000;
    localparam logic [63:0] MAX = 64'h7FEFFFFFFFFFFFFF, TINY = 64'h3C30000000000000, SNAN = 64'h7FF0000000000001;
    logic        clk_i   = 1'b0;
    logic        srst_i  = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    fsu_req_type req;
    fsu_rsp_type rsp;
    fsu_flt_type flt;
    int          miscompares  = 0;
    int          total_checks = 0;
    // 25 MHz clock
    always #20 clk_i = ~clk_i;
    fsu_issue_model u_iss (.clk_i(clk_i), .req_o(req));
    fsu_top u_dut (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .req_i(req), .rsp_o(rsp), .flt_o(flt), .irq_o(irq));
    task automatic print_verdict();
        if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; read data taken at the ready edge, bounded wait
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [31:0] erd,
                       input logic eerr);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (n > 20) begin
                miscompares++;
                print_verdict();
            end
        end while (pready !== 1'b1);
        chk({31'h0, pslverr, wr ? erd : prdata}, {31'h0, eerr, erd});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // code zero means a register write is expected, else a fault with that code
    task automatic op(input logic [31:0] ac, input logic lng, input logic [63:0] s2, input logic [63:0] s1,
                      input logic [4:0] code, input logic [63:0] res);
        apb(1'b1, `FSU_OFF_ACTRL, ac, 32'h0, 1'b0);
        // send returns at the take edge; the answer stands for the cycle after it
        u_iss.send(lng, 5'h7, s2, s1);
        #1;
        // masked exceptions may show in the code without a fault, so it counts only with a fault
        chk({57'h0, rsp.we, flt.valid, (code == 5'h0) ? 5'h00 : flt.code}, {57'h0, code == 5'h0, code != 5'h0, code});
        if (code == 5'h0) begin
            chk({rsp.word_hi, rsp.word_lo}, res);
            chk({58'h0, rsp.pair, rsp.dst_reg}, {58'h0, lng, lng ? 5'h6 : 5'h7});
        end
    endtask : op
    task automatic sc_regs();
        apb(1'b0, `FSU_OFF_ACTRL, 32'h0, 32'hF0, 1'b0);
        apb(1'b0, `FSU_OFF_IMASK, 32'h0, 32'h0, 1'b0);
        apb(1'b0, 12'h014, 32'h0, 32'h0, 1'b1);
        apb(1'b1, `FSU_OFF_IMASK, 32'h20, 32'h0, 1'b0);
        op(32'hF0, 1'b0, 64'h3FC00000, 64'h3F000000, 5'h0, 64'h3F800000);
        @(posedge clk_i);
        #1;
        chk({63'h0, irq}, 64'h1);
        apb(1'b0, `FSU_OFF_RES_LO, 32'h0, 32'h3F800000, 1'b0);
        apb(1'b1, `FSU_OFF_IMASK, 32'h0, 32'h0, 1'b0);
        @(posedge clk_i);
        #1;
        chk({63'h0, irq}, 64'h0);
        apb(1'b0, `FSU_OFF_STAT, 32'h0, 32'h20, 1'b0);
        apb(1'b1, `FSU_OFF_STAT, 32'h20, 32'h0, 1'b0);
        apb(1'b0, `FSU_OFF_STAT, 32'h0, 32'h0, 1'b0);
    endtask : sc_regs
    task automatic sc_special();
        op(32'hF0, 1'b1, 64'h4008000000000000, ONE, 5'h0, 64'h4000000000000000);
        for (int m = 0; m < 4; m++) op(32'hF0 | m, 1'b1, ONE, ONE, 5'h0, {m == 1, 63'h0});
        op(32'hF1, 1'b1, 64'h0, {1'b1, 63'h0}, 5'h0, 64'h0);
        op(32'hF0, 1'b1, {1'b1, 63'h0}, 64'h0, 5'h0, {1'b1, 63'h0});
        op(32'h00, 1'b1, INF, ONE, 5'h0, INF);
        op(32'h00, 1'b1, ONE, INF, 5'h0, NINF);
        op(32'hF0, 1'b1, INF, INF, 5'h0, 64'h7FF8000000000000);
        op(32'hB0, 1'b1, NINF, NINF, 5'h04, 64'h0);
    endtask : sc_special
    task automatic sc_nan();
        op(32'h00, 1'b1, 64'h7FF8000000000ABC, ONE, 5'h0, 64'h7FF8000000000ABC);
        op(32'hF0, 1'b1, ONE, SNAN, 5'h0, 64'h7FF8000000000001);
        op(32'hB0, 1'b1, ONE, SNAN, 5'h04, 64'h0);
    endtask : sc_nan
    task automatic sc_round();
        for (int m = 0; m < 4; m++) op(32'hF0 | m, 1'b1, ONE, TINY, 5'h0, m[0] ? 64'h3FEFFFFFFFFFFFFF : ONE);
        op(32'h70, 1'b1, ONE, TINY, 5'h08, 64'h0);
        op(32'hF0, 1'b1, MAX, {1'b1, MAX[62:0]}, 5'h0, INF);
        op(32'hF3, 1'b1, MAX, {1'b1, MAX[62:0]}, 5'h0, MAX);
        op(32'hE0, 1'b1, MAX, {1'b1, MAX[62:0]}, 5'h09, 64'h0);
        op(32'hF0, 1'b1, 64'h2, 64'h1, 5'h0, 64'h1);
        // denormal difference with underflow unmasked traps on tininess alone
        op(32'hD0, 1'b1, 64'h2, 64'h1, 5'h02, 64'h0);
        op(32'hF4, 1'b1, 64'h2, 64'h1, 5'h10, 64'h0);
    endtask : sc_round
    // reset, then every scenario in turn
    initial begin
        repeat (12) @(posedge clk_i);
        srst_i <= 1'b0;
        sc_regs();
        sc_special();
        sc_nan();
        sc_round();
        print_verdict();
    end
endmodule : tb_float_subtract_unit

// ===== rtl/fsu_map.svh
// register offsets, field positions, reset values and format constants of the float subtract unit
// assumes a 12-bit byte address on the register bus and 32-bit data
// Overview of operation
// - result written to destination is second source minus first source
// - long operands and result occupy a register pair named by its lower register
// - like-sign zero difference is +0, except -0 when rounding toward minus infinity
// - +0 minus -0 is +0; -0 minus +0 is -0 in every mode
// - exactly one infinite source and no NaN gives infinity of the expected sign, no exception but reserved-encoding
// - infinities of like sign raise invalid operation
// - unnormal or denormal operand with normalizing mode set raises reserved-encoding fault
// - overflow, underflow, invalid and inexact fault only when their mask bits allow it; reserved-encoding always faults
// - rounded difference beyond largest finite magnitude raises overflow
// - difference too small for the destination format raises underflow when underflow is unmasked or bits are lost
// - any signaling NaN source raises invalid operation
// - a difference that must be rounded raises inexact
`ifndef FSU_MAP_SVH
`define FSU_MAP_SVH
`define FSU_OFF_ACTRL   12'h000
`define FSU_OFF_STAT    12'h004
`define FSU_OFF_IMASK   12'h008
`define FSU_OFF_RES_LO  12'h00C
`define FSU_OFF_RES_HI  12'h010
`define FSU_AC_RM_LSB   0
`define FSU_AC_NORM     2
`define FSU_AC_MSK_LSB  4
`define FSU_AC_RST      32'h000000F0
`define FSU_IMASK_RST   32'h00000000
`define FSU_EV_OVF      0
`define FSU_EV_UNF      1
`define FSU_EV_INV      2
`define FSU_EV_INX      3
`define FSU_EV_RES      4
`define FSU_EV_DONE     5
`define FSU_BIAS_L      13'sh03FF
`define FSU_BIAS_S      13'sh007F
`define FSU_LSB_L       10
`define FSU_LSB_S       39
`endif

// ===== rtl/fsu_pkg.sv
// types shared by the float subtract unit and its bench
// assumes the constants of fsu_map.svh
package fsu_pkg;
    typedef enum logic [1:0] {
        FSU_RM_NEAR  = 2'h0,
        FSU_RM_DOWN  = 2'h1,
        FSU_RM_UP    = 2'h2,
        FSU_RM_ZERO  = 2'h3
    } fsu_rm_type;

    // one subtract request from the issue logic, operands already read from the register file
    typedef struct packed {
        logic        valid;
        logic        long_op;
        logic [4:0]  dst_reg;
        logic [63:0] src1;
        logic [63:0] src2;
    } fsu_req_type;

    // register file write: lo word to dst_reg, hi word to dst_reg+1 when pair is set
    typedef struct packed {
        logic        we;
        logic        pair;
        logic [4:0]  dst_reg;
        logic [31:0] word_lo;
        logic [31:0] word_hi;
    } fsu_rsp_type;

    // fault report: code bits follow the event bit positions
    typedef struct packed {
        logic        valid;
        logic [4:0]  code;
    } fsu_flt_type;
endpackage : fsu_pkg

// ===== rtl/fsu_top.sv
// float subtract unit: single and long real dst = src2 - src1, with apb register access
// assumes requests synchronous to clk_i, one per cycle at most, and an apb master
`timescale 1ns/100ps
`include "fsu_map.svh"
module fsu_top import fsu_pkg::*; (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire fsu_req_type req_i,
    output fsu_rsp_type      rsp_o,
    output fsu_flt_type      flt_o,
    output logic             irq_o
);
    logic [31:0]        ac_reg, ac_next, st_reg, st_next, im_reg, im_next;
    logic [63:0]        last_reg, last_next;
    logic [31:0]        prdata_reg, prdata_next;
    logic               pready_reg, pready_next, pslverr_reg, pslverr_next, irq_reg, irq_next;
    fsu_rsp_type        rsp_reg, rsp_next;
    fsu_flt_type        flt_reg, flt_next;
    logic [63:0]        op     [2];
    logic               sgn    [2];
    logic               zro    [2];
    logic               inf    [2];
    logic               nan    [2];
    logic               snan   [2];
    logic               den    [2];
    logic [51:0]        frc    [2];
    logic [63:0]        sig    [2];
    logic signed [12:0] ex     [2];
    logic signed [12:0] bias, e;
    logic [12:0]        d, dd;
    logic [6:0]         lz;
    logic [5:0]         lpos;
    logic [63:0]        mb, ms, sh, acc, lowm;
    logic               big, sa, sb, rs, found, g, st, inc, tiny;
    fsu_rm_type         rm;
    logic [63:0]        res;
    logic [4:0]         exc;
    logic [3:0]         msk;
    logic               flt;

    function automatic logic [63:0] pack(input logic lng, input logic s, input logic [10:0] be,
                                         input logic [51:0] f);
        pack = lng ? {s, be, f} : {32'h0000_0000, s, be[7:0], f[51:29]};
    endfunction : pack

    assign op[0] = req_i.src1;
    assign op[1] = req_i.src2;

    // unpack both operands into a common form: hidden bit at 62, unbiased exponent
    for (genvar gi = 0; gi < 2; gi++) begin : g_unp
        logic [10:0] ef;
        logic        emax;
        always_comb begin
            if (req_i.long_op) begin
                ef   = op[gi][62:52];
                frc[gi] = op[gi][51:0];
                emax = op[gi][62:52] == 11'h7FF;
                sgn[gi] = op[gi][63];
            end else begin
                ef   = {3'h0, op[gi][30:23]};
                frc[gi] = {op[gi][22:0], 29'h0};
                emax = op[gi][30:23] == 8'hFF;
                sgn[gi] = op[gi][31];
            end
            zro[gi]  = (ef == 11'h000) && (frc[gi] == 52'h0);
            den[gi]  = (ef == 11'h000) && (frc[gi] != 52'h0);
            inf[gi]  = emax && (frc[gi] == 52'h0);
            nan[gi]  = emax && (frc[gi] != 52'h0);
            snan[gi] = nan[gi] && !frc[gi][51];
            sig[gi]  = {1'b0, ef != 11'h000, frc[gi], 10'h000};
            ex[gi]   = $signed({2'b00, (ef == 11'h000) ? 11'h001 : ef})
                       - (req_i.long_op ? `FSU_BIAS_L : `FSU_BIAS_S);
        end
    end

    // datapath: align, add or subtract magnitudes, normalise, denormalise, round, pack
    always_comb begin
        rm   = fsu_rm_type'(ac_reg[`FSU_AC_RM_LSB +: 2]);
        bias = req_i.long_op ? `FSU_BIAS_L : `FSU_BIAS_S;
        lpos = req_i.long_op ? 6'(`FSU_LSB_L) : 6'(`FSU_LSB_S);
        sb   = sgn[1];
        sa   = !sgn[0];                                        // src1 enters negated
        big  = !((ex[0] > ex[1]) || ((ex[0] == ex[1]) && (sig[0] > sig[1])));
        mb   = big ? sig[1] : sig[0];
        ms   = big ? sig[0] : sig[1];
        rs   = big ? sb : sa;
        e    = big ? ex[1] : ex[0];
        d    = 13'(big ? ex[1] - ex[0] : ex[0] - ex[1]);
        // alignment keeps a sticky bit so that rounding still sees shifted-out ones
        if (d > 13'd63) begin
            sh = {63'h0, |ms};
        end else begin
            sh = (ms >> d) | {63'h0, |(ms & ~({64{1'b1}} << d))};
        end
        acc = (sb == sa) ? mb + sh : mb - sh;
        if (acc[63]) begin
            acc = {1'b0, acc[63:2], acc[1] | acc[0]};
            e   = e + 13'sd1;
        end
        lz    = 7'h00;
        found = 1'b0;
        for (int i = 62; i >= 0; i--) begin
            if (!found) begin
                if (acc[i]) begin
                    found = 1'b1;
                end else begin
                    lz = lz + 7'h01;
                end
            end
        end
        if (found) begin
            acc = acc << lz;
            e   = e - $signed({6'h00, lz});
        end
        // results below the normal range are shifted into denormal form before rounding
        dd = 13'((13'sd1 - bias) - e);
        if (found && (e < 13'sd1 - bias)) begin
            if (dd > 13'd63) begin
                acc = {63'h0, |acc};
            end else begin
                acc = (acc >> dd) | {63'h0, |(acc & ~({64{1'b1}} << dd))};
            end
            e = 13'sd1 - bias;
        end
        lowm = (64'h1 << (lpos - 6'h01)) - 64'h1;
        g    = acc[lpos - 6'h01];
        st   = |(acc & lowm);
        case (rm)
            FSU_RM_NEAR: inc = g && (st || acc[lpos]);
            FSU_RM_DOWN: inc = rs && (g || st);
            FSU_RM_UP:   inc = !rs && (g || st);
            default:     inc = 1'b0;
        endcase
        acc = (acc & ~((64'h1 << lpos) - 64'h1)) + ({63'h0, inc} << lpos);
        if (acc[63]) begin
            acc = acc >> 1;
            e   = e + 13'sd1;
        end
        tiny = !acc[62];
        exc  = 5'h00;
        exc[`FSU_EV_INX] = g || st;
        // masked, underflow also needs a lost bit; unmasked, a tiny nonzero result traps by itself
        exc[`FSU_EV_UNF] = found && tiny && ((g || st) || !ac_reg[`FSU_AC_MSK_LSB + `FSU_EV_UNF]);
        res = pack(req_i.long_op, rs, acc[62] ? 11'(e + bias) : 11'h000, acc[61:10]);
        if (!found) begin
            // exact zero: unlike signs keep src2's sign, like signs depend on the mode
            res = pack(req_i.long_op, (sb == sa) ? sb : (rm == FSU_RM_DOWN), 11'h000, 52'h0);
        end else if (e > bias) begin
            exc[`FSU_EV_OVF] = 1'b1;
            exc[`FSU_EV_INX] = 1'b1;
            if ((rm == FSU_RM_ZERO) || (rm == FSU_RM_UP && rs) || (rm == FSU_RM_DOWN && !rs)) begin
                res = pack(req_i.long_op, rs, 11'h7FE, {52{1'b1}});
            end else begin
                res = pack(req_i.long_op, rs, 11'h7FF, 52'h0);
            end
        end
        // special operands override the arithmetic result
        if (nan[0] || nan[1]) begin
            exc = 5'h00;
            exc[`FSU_EV_INV] = snan[0] || snan[1];
            res = nan[1] ? pack(req_i.long_op, sgn[1], 11'h7FF, frc[1] | 52'h8_0000_0000_0000)
                         : pack(req_i.long_op, sgn[0], 11'h7FF, frc[0] | 52'h8_0000_0000_0000);
        end else if (inf[0] && inf[1] && (sgn[0] == sgn[1])) begin
            exc = 5'h00;
            exc[`FSU_EV_INV] = 1'b1;
            res = pack(req_i.long_op, 1'b0, 11'h7FF, 52'h8_0000_0000_0000);
        end else if (inf[0] || inf[1]) begin
            exc = 5'h00;
            res = pack(req_i.long_op, inf[1] ? sb : sa, 11'h7FF, 52'h0);
        end
        exc[`FSU_EV_RES] = ac_reg[`FSU_AC_NORM] && (den[0] || den[1]);
        msk = ac_reg[`FSU_AC_MSK_LSB +: 4];
        flt = exc[`FSU_EV_RES] || |(exc[3:0] & ~msk);
    end

    // result and fault ports; the pair base is forced even since an odd base is illegal
    always_comb begin
        rsp_next         = rsp_reg;
        rsp_next.we      = 1'b0;
        flt_next         = '0;
        last_next        = last_reg;
        if (req_i.valid) begin
            flt_next.valid   = flt;
            flt_next.code    = exc;
            rsp_next.we      = !flt;
            rsp_next.pair    = req_i.long_op;
            rsp_next.dst_reg = req_i.long_op ? {req_i.dst_reg[4:1], 1'b0} : req_i.dst_reg;
            rsp_next.word_lo = res[31:0];
            rsp_next.word_hi = res[63:32];
            if (!flt) begin
                last_next = res;
            end
        end
    end

    // apb slave: answer one cycle into the access phase; unmapped offsets return an error
    always_comb begin
        logic acc_ph, take, mapped;
        acc_ph       = psel_i && penable_i && !pready_reg;
        take         = psel_i && penable_i && pready_reg;
        mapped       = (paddr_i == `FSU_OFF_ACTRL) || (paddr_i == `FSU_OFF_STAT) ||
                       (paddr_i == `FSU_OFF_IMASK) || (paddr_i == `FSU_OFF_RES_LO) ||
                       (paddr_i == `FSU_OFF_RES_HI);
        pready_next  = acc_ph;
        pslverr_next = acc_ph && !mapped;
        prdata_next  = 32'h0000_0000;
        if (acc_ph && !pwrite_i) begin
            case (paddr_i)
                `FSU_OFF_ACTRL:  prdata_next = ac_reg;
                `FSU_OFF_STAT:   prdata_next = st_reg;
                `FSU_OFF_IMASK:  prdata_next = im_reg;
                `FSU_OFF_RES_LO: prdata_next = last_reg[31:0];
                `FSU_OFF_RES_HI: prdata_next = last_reg[63:32];
                default:         prdata_next = 32'h0000_0000;
            endcase
        end
        ac_next = ac_reg;
        im_next = im_reg;
        st_next = st_reg;
        if (take && pwrite_i && (paddr_i == `FSU_OFF_ACTRL)) begin
            ac_next = {24'h00_0000, pwdata_i[7:4], 1'b0, pwdata_i[2:0]};
        end
        if (take && pwrite_i && (paddr_i == `FSU_OFF_IMASK)) begin
            im_next = {26'h000_0000, pwdata_i[5:0]};
        end
        if (take && pwrite_i && (paddr_i == `FSU_OFF_STAT)) begin
            st_next = st_reg & ~pwdata_i;                       // write one to clear
        end
        // a new event in the clearing cycle wins over the clear
        if (req_i.valid) begin
            st_next = st_next | {26'h000_0000, 1'b1, exc};
        end
        irq_next = |(st_next & im_next);
    end

    // all state registers; outputs are taken straight from these
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ac_reg      <= `FSU_AC_RST;
            im_reg      <= `FSU_IMASK_RST;
            st_reg      <= 32'h0000_0000;
            last_reg    <= 64'h0;
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg     <= 1'b0;
            rsp_reg     <= '0;
            flt_reg     <= '0;
        end else begin
            ac_reg      <= ac_next;
            im_reg      <= im_next;
            st_reg      <= st_next;
            last_reg    <= last_next;
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_reg     <= irq_next;
            rsp_reg     <= rsp_next;
            flt_reg     <= flt_next;
        end
    end

    assign prdata_o  = prdata_reg;
    assign pready_o  = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign rsp_o     = rsp_reg;
    assign flt_o     = flt_reg;
    assign irq_o     = irq_reg;
endmodule : fsu_top
